/* rtl/asq_sequencer.sv */
// sequencer control and decode of instruction section 0
// assumes host register strobes on the core clock; trigger pin is async
module asq_sequencer (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // host register access
  input  wire logic        ram_we_i,
  input  wire logic        ram_re_i,
  input  wire logic [2:0]  ram_addr_i,
  input  wire logic [1:0]  ram_ptr_i,
  input  wire logic [15:0] ram_wdata_i,
  output logic      [15:0] ram_rdata_o,
  input  wire logic        start_set_i,
  input  wire logic        start_clr_i,
  input  wire logic        soft_reset_i,
  input  wire logic        trig_dir_i,
  output logic             start_o,
  output logic      [2:0]  exec_addr_o,
  output logic             halt_int_o,
  // external trigger and timing
  input  wire logic        trig_pin_i,
  input  wire logic        acq_done_i,
  input  wire logic        conv_done_i,
  input  wire logic [15:0] timer_i,
  // decoded controls
  output logic      [2:0]  pos_sel_o,
  output logic      [2:0]  neg_sel_o,
  output logic             neg_ground_o,
  output logic             res_8bit_o,
  output logic             cmp_mode_o,
  output logic      [3:0]  acq_time_o,
  output logic             acq_start_o,
  output logic             conv_start_o,
  output logic             limit_sel_o,
  output logic             timer_wait_o
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  asq_pkg::asq_state_t state_ff, nxt_state;
  logic [2:0]  pc_ff;
  logic [2:0]  nxt_pc;
  logic [15:0] instr_ff;
  logic        start_ff;
  logic        first_ff;
  logic        limit_ff;
  logic        int_ff;
  logic [2:0]  trig_sync_ff;
  logic        trig_seen_ff;
  logic [15:0] mem_rdata;
  logic [2:0]  mem_raddr;

  // ----------------------------------------------------------------
  // host access decode
  // ----------------------------------------------------------------
  // only section 0 is held here
  wire sect0_hit   = ram_ptr_i == asq_pkg::SECT0_PTR;
  wire mem_we      = ram_we_i & sect0_hit;
  wire host_read   = ram_re_i & sect0_hit;

  // read address: a section 0 host read wins when strobed, else the next program counter
  assign mem_raddr = host_read ? ram_addr_i : nxt_pc;

  asq_sect0_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (ram_addr_i),
    .wdata_i (ram_wdata_i),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  assign ram_rdata_o = mem_rdata;

  // ----------------------------------------------------------------
  // trigger pin synchroniser and edge detect
  // ----------------------------------------------------------------
  // input only when direction bit is zero
  wire trig_level  = trig_sync_ff[1] & trig_sync_ff[2];
  wire trig_rise   = trig_level & ~trig_seen_ff & ~trig_dir_i;

  // three flops, change counted once the last two agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trig_sync_ff <= 3'h0;
      trig_seen_ff <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[1:0], trig_pin_i};
      if (trig_sync_ff[1] == trig_sync_ff[2]) begin
        trig_seen_ff <= trig_sync_ff[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // instruction field decode
  // ----------------------------------------------------------------
  wire f_wrap  = instr_ff[asq_pkg::WRAP_BIT];
  wire f_halt  = instr_ff[asq_pkg::HALT_BIT];
  wire f_trig  = instr_ff[asq_pkg::TRIG_BIT];
  wire f_delay = instr_ff[asq_pkg::DELAY_BIT];
  wire f_cmp   = instr_ff[asq_pkg::CMP_BIT];

  assign pos_sel_o    = instr_ff[asq_pkg::POS_LSB +: 3];
  assign neg_sel_o    = instr_ff[asq_pkg::NEG_LSB +: 3];
  assign neg_ground_o = neg_sel_o == asq_pkg::NEG_GROUND;
  assign res_8bit_o   = instr_ff[asq_pkg::RES_BIT];
  assign cmp_mode_o   = f_cmp;
  assign acq_time_o   = instr_ff[asq_pkg::ACQ_LSB +: 4];
  assign limit_sel_o  = limit_ff;
  assign start_o      = start_ff;
  assign exec_addr_o  = pc_ff;
  assign halt_int_o   = int_ff;
  assign timer_wait_o = state_ff == asq_pkg::ASQ_DELAY;

  // ----------------------------------------------------------------
  // sequencer conditions
  // ----------------------------------------------------------------
  // halt ignored on the first run of instruction zero
  wire halt_now    = f_halt & ~first_ff;
  wire timer_zero  = timer_i == asq_pkg::TIMER_ZERO;
  wire last_instr  = f_wrap | (pc_ff == asq_pkg::INSTR_LAST);
  // second limit pass still to come in compare mode
  wire more_cmp    = f_cmp & ~limit_ff;

  assign acq_start_o  = state_ff == asq_pkg::ASQ_ACQ;
  // capture and convert on the edge after the trigger
  assign conv_start_o = (state_ff == asq_pkg::ASQ_TRIG) & trig_rise;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    case (state_ff)
      asq_pkg::ASQ_IDLE: begin
        nxt_state = asq_pkg::ASQ_IDLE;
      end
      asq_pkg::ASQ_FETCH: begin
        nxt_state = asq_pkg::ASQ_WSTART;
      end
      asq_pkg::ASQ_WSTART: begin
        // wait for start, then honour halt unless first run
        if (start_ff && !halt_now) begin
          nxt_state = f_delay ? asq_pkg::ASQ_DELAY : asq_pkg::ASQ_ACQ;
        end
      end
      asq_pkg::ASQ_DELAY: begin
        if (timer_zero) begin
          nxt_state = asq_pkg::ASQ_NEXT;
        end
      end
      asq_pkg::ASQ_ACQ: begin
        if (acq_done_i) begin
          nxt_state = f_trig ? asq_pkg::ASQ_TRIG : asq_pkg::ASQ_CONV;
        end
      end
      asq_pkg::ASQ_TRIG: begin
        if (trig_rise) begin
          nxt_state = asq_pkg::ASQ_CONV;
        end
      end
      asq_pkg::ASQ_CONV: begin
        if (conv_done_i) begin
          // compare mode runs twice, each pass may wait a trigger
          if (more_cmp) begin
            nxt_state = f_trig ? asq_pkg::ASQ_TRIG : asq_pkg::ASQ_CONV;
          end else begin
            nxt_state = asq_pkg::ASQ_NEXT;
          end
        end
      end
      asq_pkg::ASQ_NEXT: begin
        // wrap or eighth instruction returns to zero
        nxt_pc    = last_instr ? asq_pkg::INSTR_ZERO : pc_ff + 3'h1;
        nxt_state = asq_pkg::ASQ_FETCH;
      end
      default: begin
        nxt_state = asq_pkg::ASQ_IDLE;
      end
    endcase
    if (soft_reset_i) begin
      nxt_pc    = asq_pkg::INSTR_ZERO;
      nxt_state = asq_pkg::ASQ_FETCH;
    end
  end

  // ----------------------------------------------------------------
  // state, program counter and instruction registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= asq_pkg::ASQ_IDLE;
      pc_ff    <= asq_pkg::INSTR_ZERO;
      instr_ff <= asq_pkg::SECT0_RESET;
    end else begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      if (state_ff == asq_pkg::ASQ_FETCH) begin
        instr_ff <= mem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // first-run flag and compare pass
  // ----------------------------------------------------------------
  wire leave_wait = (state_ff == asq_pkg::ASQ_WSTART) & start_ff & ~halt_now;
  wire conv_end   = (state_ff == asq_pkg::ASQ_CONV) & conv_done_i;
  wire halt_hit   = (state_ff == asq_pkg::ASQ_WSTART) & start_ff & halt_now;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      first_ff <= 1'b1;
      limit_ff <= 1'b0;
    end else begin
      // armed by soft reset or a halt, so a restart executes at once
      if (soft_reset_i || halt_hit) begin
        first_ff <= 1'b1;
      end else if (leave_wait) begin
        first_ff <= 1'b0;
      end
      if (conv_end) begin
        limit_ff <= more_cmp;
      end else if (state_ff == asq_pkg::ASQ_NEXT) begin
        limit_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // start bit and halt interrupt
  // ----------------------------------------------------------------
  // host set wins over the hardware clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      start_ff <= 1'b0;
      int_ff   <= 1'b0;
    end else begin
      if (start_set_i) begin
        start_ff <= 1'b1;
      end else if (halt_hit || start_clr_i) begin
        start_ff <= 1'b0;
      end
      // halt event wins over the clear by restart
      if (halt_hit) begin
        int_ff <= 1'b1;
      end else if (start_set_i) begin
        int_ff <= 1'b0;
      end
    end
  end

endmodule : asq_sequencer

/* rtl/asq_pkg.sv */
// constants for the acquisition sequencer and instruction decode block
// assumes a single 200 MHz clock and a host that writes registers as pins
// What this block does
// - wrap flag set: the executing instruction is last, instruction zero follows
// - halt flag on fetch: stop before execution and clear the start bit
// - a halt from the halt flag raises the halt interrupt
// - host writes start bit one to resume; device then continues executing
// - after soft reset fetch and decode instruction zero, wait for start
// - first execution of instruction zero after start ignores its halt flag
// - after wrap or eight instructions, instruction zero halt flag stops it
// - bits two to four pick the non-inverting analog input
// - bits five to seven pick inverting input; code zero selects ground
// - trigger-wait flag suspends after acquisition until trigger rising edge
// - after trigger edge, capture and start conversion on next clock edge
// - compare mode with trigger wait needs two edges, one per limit
// - delay-wait flag halts until the 16-bit down-timer reaches zero
// - resolution bit one selects 8+sign, zero selects 12+sign
// - compare flag one does two limit comparisons, else a conversion
// - this section is addressed when the section pointer equals zero
package asq_pkg;

  // ----------------------------------------------------------------
  // instruction section 0 field positions
  // ----------------------------------------------------------------
  localparam int WRAP_BIT     = 0;
  localparam int HALT_BIT     = 1;
  localparam int POS_LSB      = 2;
  localparam int NEG_LSB      = 5;
  localparam int TRIG_BIT     = 8;
  localparam int DELAY_BIT    = 9;
  localparam int RES_BIT      = 10;
  localparam int CMP_BIT      = 11;
  localparam int ACQ_LSB      = 12;

  // ----------------------------------------------------------------
  // sizes and pointer values
  // ----------------------------------------------------------------
  localparam int          NUM_INSTR   = 8;
  localparam logic [1:0]  SECT0_PTR   = 2'h0;
  localparam logic [2:0]  INSTR_ZERO  = 3'h0;
  localparam logic [2:0]  INSTR_LAST  = 3'h7;
  localparam logic [2:0]  NEG_GROUND  = 3'h0;
  localparam logic [15:0] SECT0_RESET = 16'h0000;
  localparam logic [15:0] TIMER_ZERO  = 16'h0000;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ASQ_IDLE    = 8'h01,
    ASQ_FETCH   = 8'h02,
    ASQ_WSTART  = 8'h04,
    ASQ_ACQ     = 8'h08,
    ASQ_TRIG    = 8'h10,
    ASQ_CONV    = 8'h20,
    ASQ_DELAY   = 8'h40,
    ASQ_NEXT    = 8'h80
  } asq_state_t;

endpackage : asq_pkg

/* rtl/asq_sect0_mem.sv */
// eight-word store of instruction section 0, registered read port
// assumes writes arrive only while the sequencer is stopped
module asq_sect0_mem (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [2:0]  waddr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [2:0]  raddr_i,
  output logic      [15:0] rdata_o
);

  logic [15:0] mem_ff [asq_pkg::NUM_INSTR];

  // write port and registered read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_ff[raddr_i];
  end

endmodule : asq_sect0_mem

/* bench/asq_sequencer_sva.sv */
// checks on the sequencer top ports
// assumes one clock and a synchronous active-high reset
module asq_sequencer_sva (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        start_set_i,
  input wire logic        start_clr_i,
  input wire logic        soft_reset_i,
  input wire logic        trig_dir_i,
  input wire logic [15:0] timer_i,
  input wire logic        start_o,
  input wire logic [2:0]  exec_addr_o,
  input wire logic        halt_int_o,
  input wire logic [2:0]  neg_sel_o,
  input wire logic        neg_ground_o,
  input wire logic        cmp_mode_o,
  input wire logic        acq_start_o,
  input wire logic        conv_start_o,
  input wire logic        limit_sel_o,
  input wire logic        timer_wait_o
);
  // ----------------------------------------------------------------
  // sequencing and decode properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_halt_drops_start: assert property (
    $rose(halt_int_o) |-> ##[0:1] !start_o) else $error("start kept");
  chk_halt_gives_int: assert property (
    $fell(start_o) && !$past(start_clr_i) && !$past(soft_reset_i)
    |-> ##[0:1] halt_int_o) else $error("no halt int");
  chk_resume_runs: assert property (
    start_set_i |=> start_o && !halt_int_o) else $error("no resume");
  chk_soft_fetch: assert property (
    soft_reset_i |-> ##2 exec_addr_o == asq_pkg::INSTR_ZERO)
    else $error("soft reset index");
  chk_neg_ground: assert property (
    neg_ground_o == (neg_sel_o == asq_pkg::NEG_GROUND))
    else $error("ground select");
  chk_trig_dir_gate: assert property (
    conv_start_o |-> !trig_dir_i) else $error("output pin edge taken");
  chk_timer_quiet: assert property (
    timer_wait_o |-> !conv_start_o && !acq_start_o) else $error("busy");
  chk_timer_holds: assert property (
    timer_wait_o && timer_i != asq_pkg::TIMER_ZERO && !soft_reset_i
    |=> timer_wait_o) else $error("timer wait left early");
  chk_limit_pair: assert property (
    $rose(limit_sel_o) |-> cmp_mode_o) else $error("limit two");
  chk_addr_step: assert property (
    $changed(exec_addr_o) |-> exec_addr_o == asq_pkg::INSTR_ZERO
    || exec_addr_o == $past(exec_addr_o) + 3'h1) else $error("index");

  cov_halt: cover property ($rose(halt_int_o));
  cov_limit2: cover property (conv_start_o && limit_sel_o);
  cov_timer: cover property ($fell(timer_wait_o));
endmodule : asq_sequencer_sva

bind asq_sequencer asq_sequencer_sva u_sva (
  .clk_i, .reset_i, .start_set_i, .start_clr_i, .soft_reset_i,
  .trig_dir_i, .timer_i, .start_o, .exec_addr_o, .halt_int_o,
  .neg_sel_o, .neg_ground_o, .cmp_mode_o, .acq_start_o,
  .conv_start_o, .limit_sel_o, .timer_wait_o
);

/* bench/asq_far_model.sv */
// far side: sample-and-hold timing, converter and down-timer
// assumes the bench says whether a step waits for a trigger
module asq_far_model #(
  parameter int ACQ_CYC     = 6,
  parameter int CONV_CYC    = 5,
  parameter int TIMER_START = 20
) (
  input  wire logic        clk_i,
  input  wire logic        acq_start_i,
  input  wire logic        conv_start_i,
  input  wire logic        timer_wait_i,
  input  wire logic        wait_trig_i,
  output logic             acq_done_o,
  output logic             conv_done_o,
  output logic      [15:0] timer_o
);
  // ----------------------------------------------------------------
  // done pulses and timer
  // ----------------------------------------------------------------
  task automatic pulse(ref logic s, input int d);
    repeat (d) @(posedge clk_i);
    #1 s = 1'b1;
    @(posedge clk_i);
    #1 s = 1'b0;
  endtask : pulse

  initial begin
    acq_done_o = 1'b0;
    conv_done_o = 1'b0;
    timer_o = 16'(TIMER_START);
  end
  // acquisition, then an untriggered step converts at once
  always begin : sh_timing
    @(posedge clk_i iff acq_start_i);
    pulse(acq_done_o, ACQ_CYC);
    if (!wait_trig_i) pulse(conv_done_o, CONV_CYC);
    wait (!acq_start_i);
  end
  // a triggered launch finishes after the conversion time
  always begin : converter
    @(posedge clk_i iff conv_start_i);
    pulse(conv_done_o, CONV_CYC);
  end
  // loads on entry to the wait, counts down to zero
  always @(posedge clk_i) begin : down_timer
    if (!timer_wait_i) timer_o <= 16'(TIMER_START);
    else if (timer_o != 16'h0000) timer_o <= timer_o - 16'h0001;
  end
endmodule : asq_far_model

/* bench/acq_sequencer_instruction_decode_test.sv */
// self-checking bench for the acquisition sequencer
// assumes asq_far_model on the far side and the bound checker
module acq_sequencer_instruction_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TS = 20;
  logic        clk_i, reset_i, ram_we_i, ram_re_i, start_set_i;
  logic        start_clr_i, soft_reset_i, trig_dir_i, trig_pin_i, wtrig;
  logic        acq_done_i, conv_done_i, start_o, halt_int_o, neg_ground_o;
  logic        res_8bit_o, cmp_mode_o, acq_start_o, conv_start_o;
  logic        limit_sel_o, timer_wait_o;
  logic [1:0]  ram_ptr_i;
  logic [2:0]  ram_addr_i, exec_addr_o, pos_sel_o, neg_sel_o;
  logic [3:0]  acq_time_o;
  logic [15:0] ram_wdata_i, ram_rdata_o, timer_i;
  int          n_errors = 0;
  int          n_compared = 0;
  // ----------------------------------------------------------------
  // design, far side and clock
  // ----------------------------------------------------------------
  asq_sequencer u_dut (.clk_i, .reset_i, .ram_we_i, .ram_re_i, .ram_addr_i,
    .ram_ptr_i, .ram_wdata_i, .ram_rdata_o, .start_set_i, .start_clr_i,
    .soft_reset_i, .trig_dir_i, .start_o, .exec_addr_o, .halt_int_o,
    .trig_pin_i, .acq_done_i, .conv_done_i, .timer_i, .pos_sel_o,
    .neg_sel_o, .neg_ground_o, .res_8bit_o, .cmp_mode_o, .acq_time_o,
    .acq_start_o, .conv_start_o, .limit_sel_o, .timer_wait_o);
  asq_far_model #(.TIMER_START(TS)) u_far (.clk_i, .acq_start_i(acq_start_o),
    .conv_start_i(conv_start_o), .timer_wait_i(timer_wait_o),
    .wait_trig_i(wtrig), .acq_done_o(acq_done_i),
    .conv_done_o(conv_done_i), .timer_o(timer_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic chk(input string s, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [1:0] p, input logic [2:0] a, input logic [15:0] d);
    {ram_ptr_i, ram_addr_i, ram_wdata_i, ram_we_i} = {p, a, d, 1'b1};
    cyc(1);
    ram_we_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    {ram_ptr_i, ram_addr_i, ram_re_i} = {2'h0, a, 1'b1};
    cyc(1);
    ram_re_i = 1'b0;
    chk("rdata", ram_rdata_o, exp);
  endtask : rd
  task automatic go(input logic [15:0] w0, input logic [15:0] w1 = 16'h0001);
    reset_i = 1'b1;
    cyc(16);
    reset_i = 1'b0;
    wr(2'h0, 3'h0, w0);
    wr(2'h0, 3'h1, w1);
    soft_reset_i = 1'b1;
    cyc(1);
    soft_reset_i = 1'b0;
    cyc(2);
  endtask : go
  task automatic st();
    start_set_i = 1'b1;
    cyc(1);
    start_set_i = 1'b0;
  endtask : st
  task automatic edge_seen(output int n, output logic ls);
    {n, ls, trig_pin_i} = {32'h0, 1'b0, 1'b1};
    for (int k = 0; k < 16; k++) begin
      if (k == 8) trig_pin_i = 1'b0;
      if (conv_start_o === 1'b1) ls = limit_sel_o;
      n += int'(conv_start_o === 1'b1);
      cyc(1);
    end
  endtask : edge_seen
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_decode();
    logic [2:0] c, nc;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      nc = ~c;
      go({1'b1, c, c[1], c[0], 2'b00, nc, c, 2'b00});
      chk("pos", 16'(pos_sel_o), 16'(c));
      chk("neg", 16'({neg_sel_o, neg_ground_o}), 16'({nc, c == 3'h7}));
      chk("res", 16'(res_8bit_o), 16'(c[0]));
      chk("cmp", 16'(cmp_mode_o), 16'(c[1]));
      chk("acq", 16'(acq_time_o), 16'({1'b1, c}));
    end
    wr(2'h1, 3'h0, 16'hFFFF);
    rd(3'h0, 16'hFC1C);
  endtask : s_decode
  task automatic s_halt();
    int n;
    go(16'h0002);
    st();
    chk("start", 16'(start_o), 16'h0001);
    n = 0;
    for (int k = 0; k < 400 && start_o; k++) begin
      n += int'(acq_start_o);
      cyc(1);
    end
    chk("first", 16'(n >= 2), 16'h0001);
    chk("halt", 16'({halt_int_o, start_o}), 16'h0002);
    chk("wrap", 16'(exec_addr_o), 16'h0000);
    st();
    chk("resume", 16'({start_o, halt_int_o}), 16'h0002);
    cyc(3);
    chk("rerun", 16'({acq_start_o, start_o}), 16'h0003);
  endtask : s_halt
  task automatic s_trig();
    int n;
    logic ls;
    {wtrig, trig_dir_i} = 2'b11;
    go(16'h0901);
    st();
    cyc(20);
    edge_seen(n, ls);
    chk("dir", 16'(n), 16'h0000);
    trig_dir_i = 1'b0;
    edge_seen(n, ls);
    chk("lim1", 16'({n[3:0], ls}), 16'h0002);
    cyc(20);
    edge_seen(n, ls);
    chk("lim2", 16'({n[3:0], ls}), 16'h0003);
  endtask : s_trig
  task automatic s_timer();
    int n;
    wtrig = 1'b0;
    go(16'h0201);
    st();
    for (n = 0; n < 40 && !timer_wait_o; n++) cyc(1);
    for (n = 0; n < 100 && timer_wait_o; n++) cyc(1);
    chk("span", 16'(n >= TS && n <= TS + 3), 16'h0001);
  endtask : s_timer
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin : main
    {ram_we_i, ram_re_i, start_set_i, start_clr_i, soft_reset_i} = '0;
    {trig_dir_i, trig_pin_i, wtrig, ram_ptr_i, ram_addr_i} = '0;
    ram_wdata_i = 16'h0000;
    s_decode();
    s_halt();
    s_trig();
    s_timer();
    summarize();
  end
  initial begin : watchdog
    #100000;
    n_errors++;
    summarize();
  end
endmodule : acq_sequencer_instruction_decode_test
